// *** hdl/cpu_state_reset_interrupt.sv ***
// Purpose: core registers, stack, reset entry and interrupt sequencing
// Assumes: instruction sequencer on the same clock issues cmd words
// Notes: Avalon-MM slave reaches the 8192-byte space; vectors via ext bus
// What this block does
// - Decode 8192-byte space, internal and external
// - Low 128 addresses internal, read and write
// - Internal reads ignore the external data bus
// - Stack pointer six bits, upper fixed 0000001
// - Push decrements, pull increments, wraps at 64
// - Call pushes two bytes, interrupt five
// - Low counter byte first; pull reverses order
// - Program counter 13 bits, A, X 8
// - Five flag bits, set reads one
// - Carry follows ALU carry or borrow
// - Zero on zero result, sign copies bit7
// - Half carry from bit 3 into 4
// - Masked external edge stays latched until taken
// - Reset on power-up or low pin
// - Wait 1920 cycles, then follow pin
// - Finish instruction, stack, then set mask
// - Return restores frame and resumes there
// - Check pending interrupts at instruction end
// - External interrupt beats timer interrupt
// - Trap runs even while mask set
// - External vector at 1FFA and 1FFB
// - Timer vector 1FF8, from wait 1FF6
// - Trap vector 1FFC, after hardware interrupts
//
// Design decisions made here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "core_defs.svh"
module cpu_state_reset_interrupt (
   input wire logic clk,
   input wire logic rst,
   input wire logic reset_pin_n,
   input wire logic irq_pin_n,
   input wire logic timer_req,
   input wire logic wait_mode,
   input wire logic cmd_valid,
   input wire core_pkg::cmd_s cmd,
   output logic cmd_ready,
   output core_pkg::regs_s regs,
   output logic reset_active,
   output core_pkg::ext_s ext,
   input wire logic ext_ack,
   input wire logic [7:0] ext_rdata,
   input wire logic [12:0] av_address,
   input wire logic av_read,
   input wire logic av_write,
   input wire logic [7:0] av_writedata,
   output logic [7:0] av_readdata,
   output logic av_waitrequest
);
   core_pkg::state_e state;
   logic rst_pin_s1, rst_pin_s2, irq_s1, irq_s2, irq_s3;
   logic [`POR_W-1:0] por_cnt;
   logic por_done, core_reset, ext_pend, hw_pend, hw_go;
   logic take, av_go, av_int, ext_clear, rd_io;
   logic [2:0] step, frame;
   logic is_irq;
   logic [12:0] vec_addr, irq_vec;
   logic [7:0] vec_hi, io_q, ram_q, mem_q;
   logic [12:0] mem_addr;
   logic mem_we;
   logic [7:0] mem_wdata;
   logic [12:0] ram_index;

   function automatic logic [12:0] stack_addr(input logic [5:0] low);
      return {`STACK_HI, low};
   endfunction : stack_addr

   function automatic logic [4:0] flags_after(input logic [4:0] cur,
                                              input core_pkg::cmd_s c);
      logic [4:0] f;
      f = cur;
      if (c.upd_c) begin
         f[`FLAG_C] = c.carry;
      end
      if (c.upd_h) begin
         f[`FLAG_H] = c.half;
      end
      if (c.upd_zn) begin
         f[`FLAG_Z] = (c.data == 8'h00);
         f[`FLAG_N] = c.data[7];
      end
      return f;
   endfunction : flags_after

   function automatic logic [7:0] frame_byte(input logic [2:0] id,
                                             input core_pkg::regs_s r);
      case (id)
         3'h0: frame_byte = r.prog_counter[7:0];
         3'h1: frame_byte = {3'h0, r.prog_counter[12:8]};
         3'h2: frame_byte = r.x;
         3'h3: frame_byte = r.a;
         3'h4: frame_byte = {3'h0, r.cond_flags};
         default: frame_byte = 8'h00;
      endcase
   endfunction : frame_byte

   // Pins come from outside the clock domain
   always_ff @(posedge clk) begin
      if (rst) begin
         rst_pin_s1 <= 1'b0;
         rst_pin_s2 <= 1'b0;
         irq_s1 <= 1'b1;
         irq_s2 <= 1'b1;
         irq_s3 <= 1'b1;
      end else begin
         rst_pin_s1 <= reset_pin_n;
         rst_pin_s2 <= rst_pin_s1;
         irq_s1 <= irq_pin_n;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         por_cnt <= '0;
      end else if (!por_done) begin
         por_cnt <= por_cnt + `POR_W'(1);
      end
   end
   assign por_done = (por_cnt == `POR_TCYC);
   // power-up or low pin holds reset
   assign core_reset = !por_done || !rst_pin_s2;

   always_ff @(posedge clk) begin
      reset_active <= rst || core_reset;
   end

   // request latched while masked; new edge beats the clear
   always_ff @(posedge clk) begin
      if (rst || core_reset) begin
         ext_pend <= 1'b0;
      end else if (irq_s3 && !irq_s2) begin
         ext_pend <= 1'b1;
      end else if (ext_clear) begin
         ext_pend <= !irq_s2;
      end
   end

   assign hw_pend = ext_pend || !irq_s2 || timer_req;
   assign hw_go = hw_pend && !regs.cond_flags[`FLAG_I];
   // wait mode picks the alternate timer vector
   assign irq_vec = (ext_pend || !irq_s2) ? `VEC_EXT :
                    wait_mode ? `VEC_TMR_WAIT : `VEC_TMR;
   assign take = (state == core_pkg::S_IDLE) && cmd_ready && cmd_valid;
   assign ext_clear = take && hw_go && (ext_pend || !irq_s2) &&
                      (cmd.op == core_pkg::OP_END ||
                       cmd.op == core_pkg::OP_TRAP);
   // anything above the internal region goes outside
   assign av_int = (av_address < `INT_LIMIT);
   assign av_go = (state == core_pkg::S_IDLE) && cmd_ready && !cmd_valid &&
                  (av_read || av_write) && av_waitrequest;

   // one port shared by stacking and bus access
   always_comb begin
      mem_addr = 13'h0000;
      mem_we = 1'b0;
      mem_wdata = 8'h00;
      case (state)
         core_pkg::S_IDLE: begin
            if (av_go && av_int) begin
               mem_addr = av_address;
               mem_we = av_write;
               mem_wdata = av_writedata;
            end
         end
         core_pkg::S_PUSH: begin
            mem_addr = stack_addr(regs.stack_ptr[5:0]);
            mem_we = 1'b1;
            mem_wdata = frame_byte(step, regs);
         end
         core_pkg::S_PULL_A: begin
            mem_addr = stack_addr(regs.stack_ptr[5:0] + `SP_STEP);
         end
         default: begin
            mem_addr = 13'h0000;
         end
      endcase
   end
   assign ram_index = mem_addr - `IO_LIMIT;

   byte_mem #(.DEPTH(`IO_DEPTH), .AW(`IO_AW)) io_mem (
      .clk(clk),
      .we(mem_we && (mem_addr < `IO_LIMIT)),
      .addr(mem_addr[`IO_AW-1:0]),
      .wdata(mem_wdata),
      .rdata(io_q)
   );

   byte_mem #(.DEPTH(`RAM_DEPTH), .AW(`RAM_AW)) ram_mem (
      .clk(clk),
      .we(mem_we && (mem_addr >= `IO_LIMIT)),
      .addr(ram_index[`RAM_AW-1:0]),
      .wdata(mem_wdata),
      .rdata(ram_q)
   );

   always_ff @(posedge clk) begin
      rd_io <= (mem_addr < `IO_LIMIT);
   end
   assign mem_q = rd_io ? io_q : ram_q;

   always_ff @(posedge clk) begin
      if (rst || core_reset) begin
         state <= core_pkg::S_IDLE;
         // stack pointer to the top on reset
         regs <= '{a: 8'h00, x: 8'h00, prog_counter: 13'h0000,
                   stack_ptr: stack_addr(`SP_RESET),
                   cond_flags: `FLAG_RESET};
         cmd_ready <= 1'b0;
         ext <= '0;
         av_readdata <= 8'h00;
         av_waitrequest <= 1'b1;
         step <= 3'h0;
         frame <= 3'h0;
         is_irq <= 1'b0;
         vec_addr <= 13'h0000;
         vec_hi <= 8'h00;
      end else begin
         case (state)
            core_pkg::S_IDLE: begin
               step <= 3'h0;
               if (!cmd_ready) begin
                  cmd_ready <= 1'b1;
               end else if (take) begin
                  cmd_ready <= 1'b0;
                  case (cmd.op)
                     core_pkg::OP_END: begin
                        regs.prog_counter <= cmd.addr;
                        if (hw_go) begin
                           state <= core_pkg::S_PUSH;
                           frame <= `FRAME_IRQ;
                           is_irq <= 1'b1;
                           vec_addr <= irq_vec;
                        end
                     end
                     // zero and sign from the result
                     // half carry taken from the ALU
                     core_pkg::OP_ALU: begin
                        regs.a <= cmd.data;
                        regs.cond_flags <= flags_after(regs.cond_flags, cmd);
                     end
                     core_pkg::OP_LDX: begin
                        regs.x <= cmd.data;
                        regs.cond_flags <= flags_after(regs.cond_flags, cmd);
                     end
                     core_pkg::OP_CCW: begin
                        regs.cond_flags <= cmd.data[4:0];
                     end
                     core_pkg::OP_STK_RESET: begin
                        regs.stack_ptr <= stack_addr(`SP_RESET);
                     end
                     // call stacks only the return address
                     core_pkg::OP_CALL: begin
                        regs.prog_counter <= cmd.ret;
                        vec_addr <= cmd.addr;
                        frame <= `FRAME_CALL;
                        is_irq <= 1'b0;
                        state <= core_pkg::S_PUSH;
                     end
                     // unmasked hardware goes first, trap reruns
                     core_pkg::OP_TRAP: begin
                        frame <= `FRAME_IRQ;
                        is_irq <= 1'b1;
                        state <= core_pkg::S_PUSH;
                        if (hw_go) begin
                           vec_addr <= irq_vec;
                        end else begin
                           regs.prog_counter <= cmd.ret;
                           vec_addr <= `VEC_TRAP;
                        end
                     end
                     core_pkg::OP_RTS: begin
                        frame <= `FRAME_CALL;
                        is_irq <= 1'b0;
                        state <= core_pkg::S_PULL_A;
                     end
                     core_pkg::OP_RET_INT: begin
                        frame <= `FRAME_IRQ;
                        is_irq <= 1'b1;
                        state <= core_pkg::S_PULL_A;
                     end
                     default: begin
                        state <= core_pkg::S_IDLE;
                     end
                  endcase
               end else if (av_go) begin
                  cmd_ready <= 1'b0;
                  if (av_int) begin
                     state <= core_pkg::S_AV_MEM;
                  end else begin
                     ext <= '{req: 1'b1, we: av_write, addr: av_address,
                              wdata: av_writedata};
                     state <= core_pkg::S_AV_EXT;
                  end
               end
            end
            // low counter byte first on the way down
            core_pkg::S_PUSH: begin
               // push moves down, six bits wrap
               regs.stack_ptr <= stack_addr(regs.stack_ptr[5:0] - `SP_STEP);
               step <= step + `STEP_ONE;
               if (step == frame - `STEP_ONE) begin
                  if (is_irq) begin
                     regs.cond_flags[`FLAG_I] <= 1'b1;
                     ext <= '{req: 1'b1, we: 1'b0, addr: vec_addr,
                              wdata: 8'h00};
                     state <= core_pkg::S_VEC_HI;
                  end else begin
                     regs.prog_counter <= vec_addr;
                     state <= core_pkg::S_IDLE;
                  end
               end
            end
            core_pkg::S_PULL_A: begin
               regs.stack_ptr <= stack_addr(regs.stack_ptr[5:0] + `SP_STEP);
               state <= core_pkg::S_PULL_D;
            end
            core_pkg::S_PULL_D: begin
               case (frame - `STEP_ONE - step)
                  3'h0: regs.prog_counter[7:0] <= mem_q;
                  3'h1: regs.prog_counter[12:8] <= mem_q[4:0];
                  3'h2: regs.x <= mem_q;
                  3'h3: regs.a <= mem_q;
                  default: regs.cond_flags <= mem_q[4:0];
               endcase
               step <= step + `STEP_ONE;
               state <= (step == frame - `STEP_ONE) ? core_pkg::S_IDLE :
                        core_pkg::S_PULL_A;
            end
            // vector high byte at the lower address
            core_pkg::S_VEC_HI: begin
               if (ext_ack) begin
                  vec_hi <= ext_rdata;
                  ext.addr <= vec_addr + `VEC_NEXT;
                  state <= core_pkg::S_VEC_LO;
               end
            end
            core_pkg::S_VEC_LO: begin
               if (ext_ack) begin
                  ext.req <= 1'b0;
                  regs.prog_counter <= {vec_hi[4:0], ext_rdata};
                  state <= core_pkg::S_IDLE;
               end
            end
            core_pkg::S_AV_MEM: begin
               av_readdata <= mem_q;
               av_waitrequest <= 1'b0;
               state <= core_pkg::S_AV_ACK;
            end
            core_pkg::S_AV_EXT: begin
               if (ext_ack) begin
                  ext.req <= 1'b0;
                  av_readdata <= ext.we ? 8'h00 : ext_rdata;
                  av_waitrequest <= 1'b0;
                  state <= core_pkg::S_AV_ACK;
               end
            end
            core_pkg::S_AV_ACK: begin
               av_waitrequest <= 1'b1;
               state <= core_pkg::S_IDLE;
            end
            default: begin
               state <= core_pkg::S_IDLE;
            end
         endcase
      end
   end

   chk_sp_upper: assert property (@(posedge clk) disable iff (rst)
      regs.stack_ptr[12:6] == `STACK_HI)
      else $error("stack pointer upper bits changed");

   chk_sp_reset: assert property (@(posedge clk) disable iff (rst)
      core_reset |=> regs.stack_ptr == 13'h007f)
      else $error("stack pointer not at top after reset");

   chk_push_step: assert property (@(posedge clk)
      disable iff (rst || core_reset)
      state == core_pkg::S_PUSH |=>
         regs.stack_ptr[5:0] == $past(regs.stack_ptr[5:0]) - `SP_STEP)
      else $error("push did not step the stack pointer down");

   chk_por_hold: assert property (@(posedge clk) disable iff (rst)
      (por_cnt < `POR_TCYC) |-> core_reset ##0 reset_active[*1])
      else $error("reset released before power-up delay");

   chk_mask_hold: assert property (@(posedge clk)
      disable iff (rst || core_reset)
      take && cmd.op == core_pkg::OP_END && regs.cond_flags[`FLAG_I]
      |=> state == core_pkg::S_IDLE)
      else $error("masked interrupt was taken");

   chk_irq_entry: assert property (@(posedge clk)
      disable iff (rst || core_reset)
      take && cmd.op == core_pkg::OP_END && hw_go
      |=> state == core_pkg::S_PUSH ##4 state == core_pkg::S_PUSH
      ##1 state == core_pkg::S_VEC_HI && regs.cond_flags[`FLAG_I])
      else $error("interrupt entry did not stack five bytes");

   chk_ext_first: assert property (@(posedge clk)
      disable iff (rst || core_reset)
      take && cmd.op == core_pkg::OP_END && hw_go && ext_pend
      |=> vec_addr == `VEC_EXT)
      else $error("external interrupt lost priority");

   chk_trap_masked: assert property (@(posedge clk)
      disable iff (rst || core_reset)
      take && cmd.op == core_pkg::OP_TRAP && regs.cond_flags[`FLAG_I]
      |=> state == core_pkg::S_PUSH && vec_addr == `VEC_TRAP)
      else $error("trap refused while masked");

   chk_int_quiet: assert property (@(posedge clk)
      disable iff (rst || core_reset)
      av_go && av_int |=> !ext.req [*2])
      else $error("internal access drove the external bus");

   chk_wait_pulse: assert property (@(posedge clk) disable iff (rst)
      $fell(av_waitrequest) |=> av_waitrequest)
      else $error("waitrequest low for more than one cycle");

endmodule : cpu_state_reset_interrupt

// *** hdl/core_defs.svh ***
// Purpose: constants for the core state and exception unit
// Assumes: one 40 MHz clock, 13-bit address space
// Notes: included by the core state module only; the package does not include it
`ifndef CORE_DEFS_SVH
`define CORE_DEFS_SVH

`define ADDR_W 13
`define IO_LIMIT 13'h0010
`define INT_LIMIT 13'h0080
`define IO_DEPTH 16
`define IO_AW 4
`define RAM_DEPTH 112
`define RAM_AW 7
`define STACK_HI 7'h01
`define SP_RESET 6'h3f
`define SP_STEP 6'h01
// Power-up delay, counted in machine cycles (1920)
`define POR_TCYC 11'h780
`define POR_W 11
`define VEC_EXT 13'h1ffa
`define VEC_TMR 13'h1ff8
`define VEC_TMR_WAIT 13'h1ff6
`define VEC_TRAP 13'h1ffc
`define VEC_NEXT 13'h0001
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_I 3
`define FLAG_H 4
`define FLAG_RESET 5'h08
`define FRAME_IRQ 3'h5
`define FRAME_CALL 3'h2
`define STEP_ONE 3'h1

`endif

// *** hdl/core_pkg.sv ***
// Purpose: types shared by the core state unit
// Assumes: constants come from core_defs.svh
// Notes: nothing here holds state
package core_pkg;

   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_END = 4'h1,
      OP_ALU = 4'h2,
      OP_LDX = 4'h3,
      OP_CALL = 4'h4,
      OP_RTS = 4'h5,
      OP_TRAP = 4'h6,
      OP_RET_INT = 4'h7,
      OP_STK_RESET = 4'h8,
      OP_CCW = 4'h9
   } op_e;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_PUSH = 4'h1,
      S_PULL_A = 4'h2,
      S_PULL_D = 4'h3,
      S_VEC_HI = 4'h4,
      S_VEC_LO = 4'h5,
      S_AV_MEM = 4'h6,
      S_AV_EXT = 4'h7,
      S_AV_ACK = 4'h8
   } state_e;

   typedef struct packed {
      op_e op;
      logic [12:0] addr;
      logic [12:0] ret;
      logic [7:0] data;
      logic carry;
      logic half;
      logic upd_c;
      logic upd_h;
      logic upd_zn;
   } cmd_s;

   typedef struct packed {
      logic [7:0] a;
      logic [7:0] x;
      logic [12:0] prog_counter;
      logic [12:0] stack_ptr;
      logic [4:0] cond_flags;
   } regs_s;

   typedef struct packed {
      logic req;
      logic we;
      logic [12:0] addr;
      logic [7:0] wdata;
   } ext_s;

endpackage : core_pkg

// *** hdl/byte_mem.sv ***
// Purpose: small byte memory with registered read data
// Assumes: one write or read per cycle
// Notes: contents are not cleared by reset
`timescale 1ns/100ps
module byte_mem #(
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : byte_mem

// *** sim/ext_mem_model.sv ***
// Purpose: external memory answering the core's request bus
// Assumes: request held until ack; one byte per ack
// Notes: slow adds three wait cycles before each ack
`timescale 1ns/100ps
module ext_mem_model (
   input wire clk,
   input wire core_pkg::ext_s ext,
   input wire logic slow,
   output logic ext_ack,
   output logic [7:0] ext_rdata
);
   logic [7:0] mem [0:8191];
   logic [1:0] wait_cnt;
   initial begin
      // vectors read as address xor a5
      for (int i = 0; i < 8192; i++) begin
         mem[i] = i[7:0] ^ 8'ha5;
      end
      ext_ack = 1'b0;
      ext_rdata = 8'h00;
      wait_cnt = 2'h0;
   end
   always @(posedge clk) begin
      ext_ack <= 1'b0;
      // Stale data never stands still between answers
      ext_rdata <= ~ext_rdata;
      if (ext.req && !ext_ack) begin
         if (slow && wait_cnt != 2'h3) begin
            wait_cnt <= wait_cnt + 2'h1;
         end else begin
            wait_cnt <= 2'h0;
            ext_ack <= 1'b1;
            ext_rdata <= mem[ext.addr];
            if (ext.we) begin
               mem[ext.addr] <= ext.wdata;
            end
         end
      end
   end
endmodule : ext_mem_model

// *** sim/cpu_state_reset_interrupt_tb_top.sv ***
// Purpose: self-checking bench for the core state unit
// Assumes: external memory model holds address xor a5
// Notes: only END and TRAP instructions look for pending interrupts
`timescale 1ns/100ps
module cpu_state_reset_interrupt_tb_top;
   logic clk, rst, reset_pin_n, irq_pin_n, timer_req, wait_mode;
   logic cmd_valid, cmd_ready, reset_active, ext_ack, slow;
   logic av_read, av_write, av_waitrequest;
   core_pkg::cmd_s cmd;
   core_pkg::regs_s regs;
   core_pkg::ext_s ext;
   logic [7:0] ext_rdata, av_writedata, av_readdata, d;
   logic [12:0] av_address;
   logic [4:0] flag_exp;
   logic [31:0] lfsr;
   logic [7:0] exp_q[$];
   logic [12:0] atab [4] = '{13'h0000, 13'h0010, 13'h007f, 13'h1000};
   int err_count, checked, n;

   cpu_state_reset_interrupt dut_u (.clk(clk), .rst(rst),
      .reset_pin_n(reset_pin_n), .irq_pin_n(irq_pin_n),
      .timer_req(timer_req), .wait_mode(wait_mode), .cmd_valid(cmd_valid),
      .cmd(cmd), .cmd_ready(cmd_ready), .regs(regs),
      .reset_active(reset_active), .ext(ext), .ext_ack(ext_ack),
      .ext_rdata(ext_rdata), .av_address(av_address), .av_read(av_read),
      .av_write(av_write), .av_writedata(av_writedata),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest));
   ext_mem_model mem_u (.clk(clk), .ext(ext), .slow(slow),
      .ext_ack(ext_ack), .ext_rdata(ext_rdata));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   function automatic logic [12:0] vec_dest(input logic [12:0] v);
      logic [12:0] w;
      w = v + 13'h0001;
      return {v[4:0] ^ 5'h05, w[7:0] ^ 8'ha5};
   endfunction : vec_dest

   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic stop_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic wait_ready(input int lim);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < lim);
      if (cmd_ready !== 1'b1) begin
         err_count++;
         stop_test();
      end
   endtask : wait_ready

   task automatic run(input core_pkg::op_e op, input logic [12:0] a,
                      input logic [7:0] dat, input logic [4:0] fl);
      wait_ready(3000);
      cmd_valid <= 1'b1;
      cmd <= '{op, a, a + 13'h0003, dat, fl[0], fl[1], fl[2], fl[3], fl[4]};
      @(posedge clk);
      cmd_valid <= 1'b0;
      wait_ready(300);
   endtask : run

   task automatic av_xfer(input logic wr, input logic [12:0] a,
                          input logic [7:0] dat);
      @(posedge clk);
      av_address <= a;
      av_writedata <= dat;
      av_read <= !wr;
      av_write <= wr;
      if (!wr) begin
         exp_q.push_back(dat);
      end
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (av_waitrequest !== 1'b0 && n < 300);
      av_read <= 1'b0;
      av_write <= 1'b0;
      if (av_waitrequest !== 1'b0) begin
         err_count++;
         stop_test();
      end
   endtask : av_xfer

   // Read data is due at the edge where waitrequest is seen low
   always @(posedge clk) begin
      if (av_read === 1'b1 && av_waitrequest === 1'b0) begin
         check(13'(av_readdata), 13'(exp_q.pop_front()));
      end
   end

   initial begin
      rst = 1'b1;
      reset_pin_n = 1'b1;
      irq_pin_n = 1'b1;
      timer_req = 1'b0;
      wait_mode = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      slow = 1'b0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_address = '0;
      av_writedata = '0;
      lfsr = 32'h3b5f4f5b;
      err_count = 0;
      checked = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (1800) @(posedge clk);
      check(13'(cmd_ready), 13'h0000);
      check(13'(reset_active), 13'h0001);
      reset_pin_n <= 1'b0;
      repeat (300) @(posedge clk);
      check(13'(cmd_ready), 13'h0000);
      check(13'(reset_active), 13'h0001);
      reset_pin_n <= 1'b1;
      wait_ready(50);
      check(13'(reset_active), 13'h0000);
      check(regs.stack_ptr, 13'h007f);
      check(13'(regs.cond_flags), 13'h0008);
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         slow <= i[0];
         av_xfer(1'b1, atab[i], lfsr[7:0]);
         av_xfer(1'b0, atab[i], lfsr[7:0]);
      end
      av_xfer(1'b0, 13'h0080, 8'h25);
      $display("memory map test done");
      flag_exp = 5'h08;
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         d = lfsr[7:0] & {8{lfsr[13]}};
         run(core_pkg::OP_ALU, 13'h0000, d, lfsr[12:8]);
         flag_exp[0] = lfsr[10] ? lfsr[8] : flag_exp[0];
         flag_exp[4] = lfsr[11] ? lfsr[9] : flag_exp[4];
         flag_exp[2:1] = lfsr[12] ? {d[7], d == 8'h00} : flag_exp[2:1];
         check(13'(regs.cond_flags), 13'(flag_exp));
      end
      run(core_pkg::OP_LDX, 13'h0000, 8'h3c, 5'h00);
      check(13'(regs.x), 13'h003c);
      run(core_pkg::OP_CALL, 13'h0200, 8'h00, 5'h00);
      check(regs.stack_ptr, 13'h007d);
      run(core_pkg::OP_RTS, 13'h0000, 8'h00, 5'h00);
      check(regs.prog_counter, 13'h0203);
      for (int i = 0; i < 33; i++) begin
         run(core_pkg::OP_CALL, 13'h0200, 8'h00, 5'h00);
      end
      check(regs.stack_ptr, 13'h007d);
      run(core_pkg::OP_STK_RESET, 13'h0000, 8'h00, 5'h00);
      check(regs.stack_ptr, 13'h007f);
      $display("stack test done");
      irq_pin_n <= 1'b0;
      timer_req <= 1'b1;
      run(core_pkg::OP_END, 13'h0123, 8'h00, 5'h00);
      check(regs.stack_ptr, 13'h007f);
      // Pin goes idle while masked: the external request now rests on the edge latch alone, timer still pending
      irq_pin_n <= 1'b1;
      run(core_pkg::OP_CCW, 13'h0000, 8'h00, 5'h00);
      slow <= 1'b1;
      run(core_pkg::OP_END, 13'h0456, 8'h00, 5'h00);
      check(regs.prog_counter, vec_dest(13'h1ffa));
      check(regs.stack_ptr, 13'h007a);
      check(13'(regs.cond_flags), 13'h0008);
      av_xfer(1'b0, 13'h007f, 8'h56);
      av_xfer(1'b0, 13'h007e, 8'h04);
      av_xfer(1'b0, 13'h007d, 8'h3c);
      av_xfer(1'b0, 13'h007c, d);
      av_xfer(1'b0, 13'h007b, 8'h00);
      wait_mode <= 1'b1;
      run(core_pkg::OP_RET_INT, 13'h0000, 8'h00, 5'h00);
      check(regs.prog_counter, 13'h0456);
      check(regs.stack_ptr, 13'h007f);
      run(core_pkg::OP_END, 13'h0789, 8'h00, 5'h00);
      check(regs.prog_counter, vec_dest(13'h1ff6));
      timer_req <= 1'b0;
      wait_mode <= 1'b0;
      run(core_pkg::OP_RET_INT, 13'h0000, 8'h00, 5'h00);
      check(regs.prog_counter, 13'h0789);
      $display("interrupt test done");
      run(core_pkg::OP_TRAP, 13'h0000, 8'h00, 5'h00);
      check(regs.prog_counter, vec_dest(13'h1ffc));
      run(core_pkg::OP_TRAP, 13'h0000, 8'h00, 5'h00);
      check(regs.stack_ptr, 13'h0075);
      // pin held low past the sync latency
      reset_pin_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_pin_n <= 1'b1;
      wait_ready(3000);
      check(regs.stack_ptr, 13'h007f);
      $display("trap and pin reset test done");
      stop_test();
   end
endmodule : cpu_state_reset_interrupt_tb_top
